// ---- host_model.sv ----
// Purpose: Host model that writes, reads and clears over the command port.
// Assumes: Strobes are one-cycle pulses launched just after a rising edge.
// Notes:   Idle write data shows the inverse of the last word.
`timescale 1ns/100ps
module host_model (
  input  wire logic        clk_i,
  input  wire logic        rd_ack_i,
  input  wire logic [15:0] rd_data_i,
  output logic [7:0]       cmd_o,
  output logic [15:0]      data_o,
  output logic             wr_o,
  output logic             rd_o,
  output logic             clr_all_o,
  output logic             clr_ot_o
);
  // Quiet port from time zero
  initial {cmd_o, data_o, wr_o, rd_o, clr_all_o, clr_ot_o} = '0;
  // One write pulse
  task automatic wr(input logic [7:0] c, input logic [15:0] d);
    @(posedge clk_i);
    {cmd_o, data_o, wr_o} <= {c, d, 1'b1};
    @(posedge clk_i);
    {data_o, wr_o} <= {~d, 1'b0};
  endtask
  // One read pulse; the word is taken at the edge that sees the answer
  task automatic rd(input logic [7:0] c, output logic [15:0] d);
    int n;
    @(posedge clk_i);
    {cmd_o, rd_o} <= {c, 1'b1};
    @(posedge clk_i);
    rd_o <= 1'b0;
    n = 0;
    do begin
      @(posedge clk_i);
      n++;
    end while (rd_ack_i !== 1'b1 && n < 4);
    d = rd_data_i;
  endtask
  // Clear pulse: all flags, or the over-temperature flag alone
  task automatic clr(input logic all);
    @(posedge clk_i);
    {clr_all_o, clr_ot_o} <= {all, !all};
    @(posedge clk_i);
    {clr_all_o, clr_ot_o} <= 2'b00;
  endtask
endmodule

// ---- overtemp_fault_pkg.sv ----
// Purpose: Shared constants for the over-temperature fault response block.
// Assumes: 10 MHz core clock; command codes address the limit registers.
// Notes:   Limits use the 16-bit linear format (5-bit exponent, 11-bit mantissa).
package overtemp_fault_pkg;

  // Command codes of the limit and response registers
  localparam logic [7:0] CMD_OC_LV_FAULT_LIMIT = 8'h48;
  localparam logic [7:0] CMD_OC_WARN_LIMIT     = 8'h4a;
  localparam logic [7:0] CMD_OVERTEMP_FAULT_THRESHOLD    = 8'h4f;
  localparam logic [7:0] CMD_OT_FAULT_ACTION   = 8'h50;
  localparam logic [7:0] CMD_OVERTEMP_WARNING_THRESHOLD     = 8'h51;

  // Field positions of the fault action byte
  localparam int RESP_MSB  = 7;
  localparam int RESP_LSB  = 6;
  localparam int RETRY_MSB = 5;
  localparam int RETRY_LSB = 3;
  localparam int DELAY_MSB = 2;
  localparam int DELAY_LSB = 0;

  // Response and retry encodings
  localparam logic [1:0] RESP_IGNORE     = 2'h0;
  localparam logic [1:0] RESP_DELAY_RUN  = 2'h1;
  localparam logic [1:0] RESP_DISABLE    = 2'h2;
  localparam logic [1:0] RESP_LATCH_OFF  = 2'h3;
  localparam logic [2:0] RETRY_NONE      = 3'h0;
  localparam logic [2:0] RETRY_FOREVER   = 3'h7;

  // Values after reset: limits at the largest positive linear value, action ignore
  localparam logic [15:0] LIMIT_RESET  = 16'h7bff;
  localparam logic [7:0]  ACTION_RESET = 8'h00;

  // Delay time unit and its length in clock cycles
  localparam int unsigned CLK_FREQ_KHZ     = 10000;
  localparam int unsigned DELAY_UNIT_US    = 1000;
  localparam int unsigned UNIT_CYCLES      = (DELAY_UNIT_US * CLK_FREQ_KHZ) / 1000;

  // Fault handling states
  typedef enum logic [2:0] {
    ST_IDLE      = 3'b000,
    ST_RUN_DELAY = 3'b001,
    ST_OFF_WAIT  = 3'b010,
    ST_LATCHED   = 3'b011
  } fault_state_type;

endpackage

// ---- overtemp_fault_response.sv ----
// Purpose: Limit registers, limit comparison and over-temperature fault response.
// Assumes: Command port and readings come from logic on clk_i; control pin is async.
// Notes:   Readings and limits are linear format; other fault sources arrive as a level.
`timescale 1ns/100ps

// Contract
// - Store over-current low-voltage limit, never use it
// - Hold 16-bit over-current warning limit
// - Hold 16-bit over-temperature fault limit
// - Hold 16-bit over-temperature warning limit
// - Response 00: keep running on fault
// - Response 01: run for delay, then retry
// - Response 10: disable now, then retry
// - Response 11: off until fault cleared
// - Clear by bit, clear-all, reset, off-on
// - Retry 000: no restart, stay off
// - Retry 1-6 attempts, then latch off
// - Restart attempts spaced by delay count
// - Retry 111 retries without limit
// - Endless retry stops on off/other fault
// - Delay field selects count of units
// - Delay used for run time or spacing
module overtemp_fault_response #(
  parameter int unsigned UNIT_CYCLES = overtemp_fault_pkg::UNIT_CYCLES
) (
  input  wire logic        clk_i,
  input  wire logic        reset_n_i,
  input  wire logic [7:0]  cmd_code_i,
  input  wire logic [15:0] wr_data_i,
  input  wire logic        wr_en_i,
  input  wire logic        rd_en_i,
  input  wire logic        clear_faults_i,
  input  wire logic        clear_ot_fault_i,
  input  wire logic        operation_on_i,
  input  wire logic        ctrl_pin_i,
  input  wire logic        other_fault_off_i,
  input  wire logic [15:0] temp_reading_i,
  input  wire logic [15:0] iout_reading_i,
  output logic [15:0]      rd_data_o,
  output logic             rd_ack_o,
  output logic             output_en_o,
  output logic             ot_fault_status_o,
  output logic             ot_warn_status_o,
  output logic             oc_warn_status_o,
  output logic             retrying_o
);

  // Linear format to fixed point: mantissa shifted by exponent plus 16
  function automatic logic signed [41:0] lin_fix(input logic [15:0] v);
    logic signed [41:0] m;
    logic [4:0]         sh;
    m  = 42'(signed'(v[10:0]));
    sh = v[15:11] + 5'h10;
    return m <<< sh;
  endfunction

  logic [15:0] oc_lv_limit_q;
  logic [15:0] oc_warn_limit_q;
  logic [15:0] overtemp_fault_threshold_q;
  logic [15:0] overtemp_warning_threshold_q;
  logic [7:0]  ot_action_q;
  logic        ctrl_level;
  logic        on_cmd_q;
  logic        on_cmd_d;
  logic        off_on_seen;
  logic        ot_fault_now;
  logic        ot_warn_now;
  logic        oc_warn_now;
  logic [1:0]  resp_mode;
  logic [2:0]  retry_set;
  logic [2:0]  delay_field;
  logic [7:0]  delay_units;
  overtemp_fault_pkg::fault_state_type state_q;
  overtemp_fault_pkg::fault_state_type state_d;
  logic [31:0] cycle_cnt_q;
  logic [7:0]  unit_cnt_q;
  logic [2:0]  attempts_q;
  logic        unit_tick;
  logic        delay_done;
  logic        start_delay;
  logic        clear_any;
  logic        sel_oc_lv;
  logic        sel_oc_warn;
  logic        sel_ot_fault;
  logic        sel_ot_act;
  logic        sel_ot_warn;
  logic [15:0] rd_mux;
  logic        attempts_left;

  // Control pin crosses into the clock domain
  pin_sync ctrl_sync (
    .clk_i     (clk_i),
    .reset_n_i (reset_n_i),
    .pin_i     (ctrl_pin_i),
    .level_o   (ctrl_level)
  );

  // Command decode
  assign sel_oc_lv    = (cmd_code_i == overtemp_fault_pkg::CMD_OC_LV_FAULT_LIMIT);
  assign sel_oc_warn  = (cmd_code_i == overtemp_fault_pkg::CMD_OC_WARN_LIMIT);
  assign sel_ot_fault = (cmd_code_i == overtemp_fault_pkg::CMD_OVERTEMP_FAULT_THRESHOLD);
  assign sel_ot_act   = (cmd_code_i == overtemp_fault_pkg::CMD_OT_FAULT_ACTION);
  assign sel_ot_warn  = (cmd_code_i == overtemp_fault_pkg::CMD_OVERTEMP_WARNING_THRESHOLD);

  // Read selection, unknown codes read zero
  assign rd_mux = sel_oc_lv    ? oc_lv_limit_q :
                  sel_oc_warn  ? oc_warn_limit_q :
                  sel_ot_fault ? overtemp_fault_threshold_q :
                  sel_ot_act   ? {8'h00, ot_action_q} :
                  sel_ot_warn  ? overtemp_warning_threshold_q : 16'h0000;

  // Limit registers; the low-voltage limit only reads back
  always_ff @(posedge clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      oc_lv_limit_q    <= overtemp_fault_pkg::LIMIT_RESET;
      oc_warn_limit_q  <= overtemp_fault_pkg::LIMIT_RESET;
      overtemp_fault_threshold_q <= overtemp_fault_pkg::LIMIT_RESET;
      overtemp_warning_threshold_q  <= overtemp_fault_pkg::LIMIT_RESET;
      ot_action_q      <= overtemp_fault_pkg::ACTION_RESET;
    end else if (wr_en_i) begin
      if (sel_oc_lv)    oc_lv_limit_q    <= wr_data_i;
      if (sel_oc_warn)  oc_warn_limit_q  <= wr_data_i;
      if (sel_ot_fault) overtemp_fault_threshold_q <= wr_data_i;
      if (sel_ot_warn)  overtemp_warning_threshold_q  <= wr_data_i;
      if (sel_ot_act)   ot_action_q      <= wr_data_i[7:0];
    end
  end

  // Read answer one cycle after the strobe
  always_ff @(posedge clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      rd_data_o <= 16'h0000;
      rd_ack_o  <= 1'b0;
    end else begin
      rd_ack_o <= rd_en_i;
      if (rd_en_i) rd_data_o <= rd_mux;
    end
  end

  // Limit comparisons on the decoded linear values
  assign ot_fault_now = lin_fix(temp_reading_i) > lin_fix(overtemp_fault_threshold_q);
  assign ot_warn_now  = lin_fix(temp_reading_i) > lin_fix(overtemp_warning_threshold_q);
  assign oc_warn_now  = lin_fix(iout_reading_i) > lin_fix(oc_warn_limit_q);

  // Action byte fields and delay length
  assign resp_mode   = ot_action_q[overtemp_fault_pkg::RESP_MSB:overtemp_fault_pkg::RESP_LSB];
  assign retry_set   = ot_action_q[overtemp_fault_pkg::RETRY_MSB:overtemp_fault_pkg::RETRY_LSB];
  assign delay_field = ot_action_q[overtemp_fault_pkg::DELAY_MSB:overtemp_fault_pkg::DELAY_LSB];
  assign delay_units = 8'h01 << delay_field;

  // On command from pin and operation; an off-then-on clears a latched fault
  assign on_cmd_d    = ctrl_level & operation_on_i;
  assign off_on_seen = on_cmd_d & ~on_cmd_q;
  assign clear_any   = clear_faults_i | clear_ot_fault_i | off_on_seen;

  // Delay timer: unit ticks from a cycle divider, units counted to the target
  assign unit_tick  = (cycle_cnt_q == UNIT_CYCLES - 1);
  assign delay_done = unit_tick & (unit_cnt_q == delay_units - 8'h01);

  // Attempts remain unless this failed attempt spends the count; seven means no limit
  assign attempts_left = (retry_set == overtemp_fault_pkg::RETRY_FOREVER) |
                         (({1'b0, attempts_q} + 4'h1) < {1'b0, retry_set});

  // Next state of the fault response
  always_comb begin
    state_d     = state_q;
    start_delay = 1'b0;
    case (state_q)
      overtemp_fault_pkg::ST_IDLE: begin
        if (ot_fault_now && on_cmd_q) begin
          case (resp_mode)
            overtemp_fault_pkg::RESP_IGNORE: state_d = overtemp_fault_pkg::ST_IDLE;
            overtemp_fault_pkg::RESP_DELAY_RUN: begin
              state_d     = overtemp_fault_pkg::ST_RUN_DELAY;
              start_delay = 1'b1;
            end
            overtemp_fault_pkg::RESP_DISABLE: begin
              if (retry_set == overtemp_fault_pkg::RETRY_NONE) begin
                state_d = overtemp_fault_pkg::ST_LATCHED;
              end else begin
                state_d     = overtemp_fault_pkg::ST_OFF_WAIT;
                start_delay = 1'b1;
              end
            end
            default: state_d = overtemp_fault_pkg::ST_LATCHED;
          endcase
        end
      end
      overtemp_fault_pkg::ST_RUN_DELAY: begin
        if (!on_cmd_q) begin
          state_d = overtemp_fault_pkg::ST_IDLE;
        end else if (delay_done) begin
          if (!ot_fault_now) begin
            state_d = overtemp_fault_pkg::ST_IDLE;
          end else if (retry_set == overtemp_fault_pkg::RETRY_NONE) begin
            state_d = overtemp_fault_pkg::ST_LATCHED;
          end else begin
            state_d     = overtemp_fault_pkg::ST_OFF_WAIT;
            start_delay = 1'b1;
          end
        end
      end
      overtemp_fault_pkg::ST_OFF_WAIT: begin
        if (!on_cmd_q) begin
          state_d = overtemp_fault_pkg::ST_IDLE;
        end else if (other_fault_off_i) begin
          state_d = overtemp_fault_pkg::ST_LATCHED;
        end else if (delay_done) begin
          if (!ot_fault_now) begin
            state_d = overtemp_fault_pkg::ST_IDLE;  // Restart succeeds
          end else if (attempts_left) begin
            start_delay = 1'b1;
          end else begin
            state_d = overtemp_fault_pkg::ST_LATCHED;
          end
        end
      end
      overtemp_fault_pkg::ST_LATCHED: begin
        if (clear_any) state_d = overtemp_fault_pkg::ST_IDLE;
      end
      default: state_d = overtemp_fault_pkg::ST_IDLE;
    endcase
  end

  // State, timer and attempt registers
  always_ff @(posedge clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      state_q     <= overtemp_fault_pkg::ST_IDLE;
      cycle_cnt_q <= 32'h0000_0000;
      unit_cnt_q  <= 8'h00;
      attempts_q  <= 3'h0;
      on_cmd_q    <= 1'b0;
    end else begin
      state_q  <= state_d;
      on_cmd_q <= on_cmd_d;
      if (start_delay) begin
        cycle_cnt_q <= 32'h0000_0000;
        unit_cnt_q  <= 8'h00;
      end else if (unit_tick) begin
        cycle_cnt_q <= 32'h0000_0000;
        unit_cnt_q  <= unit_cnt_q + 8'h01;
      end else begin
        cycle_cnt_q <= cycle_cnt_q + 32'h0000_0001;
      end
      if (state_d == overtemp_fault_pkg::ST_IDLE) begin
        attempts_q <= 3'h0;
      end else if (state_q == overtemp_fault_pkg::ST_OFF_WAIT && delay_done && attempts_q != 3'h7) begin
        attempts_q <= attempts_q + 3'h1;
      end
    end
  end

  // Status flags and output enable; a new fault wins over a clear
  always_ff @(posedge clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      ot_fault_status_o <= 1'b0;
      ot_warn_status_o  <= 1'b0;
      oc_warn_status_o  <= 1'b0;
      output_en_o       <= 1'b0;
      retrying_o        <= 1'b0;
    end else begin
      ot_fault_status_o <= ot_fault_now | (ot_fault_status_o & ~clear_any);
      ot_warn_status_o  <= ot_warn_now | (ot_warn_status_o & ~(clear_faults_i | off_on_seen));
      oc_warn_status_o  <= oc_warn_now | (oc_warn_status_o & ~(clear_faults_i | off_on_seen));
      output_en_o       <= on_cmd_d & ~other_fault_off_i &
                           (state_d == overtemp_fault_pkg::ST_IDLE ||
                            state_d == overtemp_fault_pkg::ST_RUN_DELAY);
      retrying_o        <= (state_d == overtemp_fault_pkg::ST_OFF_WAIT);
    end
  end

endmodule

// ---- overtemp_fault_response_monitor.sv ----
// Purpose: Port checker for the over-temperature fault response block.
// Assumes: One clock; the action byte is mirrored from command writes.
// Notes:   Quiet windows leave out clears, writes and off commands.
`timescale 1ns/100ps
module overtemp_fault_response_monitor #(
  parameter int unsigned UNIT_CYCLES = 4
) (
  input wire logic        clk_i,
  input wire logic        reset_n_i,
  input wire logic [7:0]  cmd_code_i,
  input wire logic [15:0] wr_data_i,
  input wire logic        wr_en_i,
  input wire logic        rd_en_i,
  input wire logic        clear_faults_i,
  input wire logic        clear_ot_fault_i,
  input wire logic        operation_on_i,
  input wire logic        ctrl_pin_i,
  input wire logic        other_fault_off_i,
  input wire logic        rd_ack_o,
  input wire logic        output_en_o,
  input wire logic        ot_fault_status_o,
  input wire logic        ot_warn_status_o,
  input wire logic        retrying_o
);
  logic [7:0]  act_q;
  logic [15:0] run_q;
  logic        on_w;
  // Undisturbed on-command cycle
  assign on_w = ctrl_pin_i && operation_on_i && !other_fault_off_i && !wr_en_i
                && !clear_faults_i && !clear_ot_fault_i;
  // Action mirror and length of the current retry wait
  always_ff @(posedge clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      act_q <= 8'h00;
      run_q <= 16'h0000;
    end else begin
      if (wr_en_i && cmd_code_i == overtemp_fault_pkg::CMD_OT_FAULT_ACTION) act_q <= wr_data_i[7:0];
      run_q <= retrying_o ? run_q + 16'h0001 : 16'h0000;
    end
  end
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!reset_n_i);
  AST_RD_ACK: assert property (rd_en_i |=> rd_ack_o)
    else $error("read not answered");
  AST_NO_ACK: assert property (!rd_en_i |=> !rd_ack_o)
    else $error("answer without read");
  AST_IGNORE: assert property (on_w[*5] ##0 (act_q[7:6] == 2'h0 && output_en_o) |=> output_en_o)
    else $error("output dropped in ignore mode");
  AST_DISABLE: assert property ((ctrl_pin_i && operation_on_i && !other_fault_off_i)[*7] ##0
    ($rose(ot_fault_status_o) && act_q[7] && $past(output_en_o)) |-> !output_en_o)
    else $error("output not disabled on fault");
  AST_LATCH_HOLD: assert property (on_w[*7] ##0 (act_q[7:6] == 2'h3 && ot_fault_status_o && !output_en_o)
    |=> !output_en_o)
    else $error("latched output came back");
  AST_NO_RETRY: assert property (on_w[*7] ##0 (act_q[7:3] == 5'h10 && ot_fault_status_o && !output_en_o)
    |=> !output_en_o)
    else $error("restart with retry count zero");
  AST_RETRY_GAP: assert property (on_w[*3] ##0 (retrying_o && run_q < 16'((UNIT_CYCLES << act_q[2:0]) - 1))
    |=> retrying_o)
    else $error("retry wait too short");
  AST_WARN_HOLD: assert property (on_w[*3] ##0 ot_warn_status_o |=> ot_warn_status_o)
    else $error("warning flag lost");
endmodule
bind overtemp_fault_response overtemp_fault_response_monitor #(.UNIT_CYCLES(UNIT_CYCLES)) mon (
  .clk_i, .reset_n_i, .cmd_code_i, .wr_data_i, .wr_en_i, .rd_en_i, .clear_faults_i, .clear_ot_fault_i,
  .operation_on_i, .ctrl_pin_i, .other_fault_off_i, .rd_ack_o, .output_en_o, .ot_fault_status_o,
  .ot_warn_status_o, .retrying_o);

// ---- pin_sync.sv ----
// Purpose: Three-stage synchroniser for a pin from outside the clock domain.
// Assumes: Pin may change at any time relative to clk_i.
// Notes:   Output follows only when stages two and three agree.
`timescale 1ns/100ps
module pin_sync (
  input  wire logic clk_i,
  input  wire logic reset_n_i,
  input  wire logic pin_i,
  output logic      level_o
);

  logic meta_q;
  logic stage2_q;
  logic stage3_q;

  // Chain of three flops, stable value taken when the last two agree
  always_ff @(posedge clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      meta_q   <= 1'b0;
      stage2_q <= 1'b0;
      stage3_q <= 1'b0;
      level_o  <= 1'b0;
    end else begin
      meta_q   <= pin_i;
      stage2_q <= meta_q;
      stage3_q <= stage2_q;
      if (stage2_q == stage3_q) begin
        level_o <= stage3_q;
      end
    end
  end

endmodule

// ---- test_overtemp_fault_response.sv ----
// Purpose: Self-checking bench for the over-temperature fault response block.
// Assumes: Unit shortened to 4 cycles; readings use exponent zero.
// Notes:   Hot is one step above the limit, cool is equal to it.
`timescale 1ns/100ps
`define CHK(a, e) begin tests_run++; if ((a) !== (e)) begin mismatches++; $display("MISMATCH t=%0t %h %h", $time, a, e); end end
module test_overtemp_fault_response;
  localparam int unsigned UNIT = 4;
  logic        clk_i             = 1'b0;
  logic        reset_n_i         = 1'b0;
  logic        operation_on_i    = 1'b0;
  logic        ctrl_pin_i        = 1'b0;
  logic        other_fault_off_i = 1'b0;
  logic [15:0] temp_reading_i    = 16'h0000;
  logic [15:0] iout_reading_i    = 16'h0200;
  logic [7:0]  cmd_code_i;
  logic [15:0] wr_data_i, rd_data_o, lim, v;
  logic        wr_en_i, rd_en_i, clear_faults_i, clear_ot_fault_i, rd_ack_o, output_en_o;
  logic        ot_fault_status_o, ot_warn_status_o, oc_warn_status_o, retrying_o;
  logic [7:0]  codes [5]         = '{8'h48, 8'h4a, 8'h4f, 8'h50, 8'h51};
  logic [2:0]  rs [4]            = '{3'h0, 3'h1, 3'h3, 3'h6};
  logic [2:0]  d;
  int          w;
  int          mismatches        = 0;
  int          tests_run         = 0;
  int          cycles            = 0;
  overtemp_fault_response #(.UNIT_CYCLES(UNIT)) dut (.*);
  host_model h (.clk_i(clk_i), .rd_ack_i(rd_ack_o), .rd_data_i(rd_data_o), .cmd_o(cmd_code_i),
    .data_o(wr_data_i), .wr_o(wr_en_i), .rd_o(rd_en_i), .clr_all_o(clear_faults_i), .clr_ot_o(clear_ot_fault_i));
  initial forever #50 clk_i = ~clk_i;
  // Hang guard
  always @(posedge clk_i) begin
    cycles++;
    if (cycles == 6000) begin
      mismatches++;
      print_verdict();
    end
  end
  task automatic print_verdict();
    $display("comparisons %0d mismatches %0d", tests_run, mismatches);
    if (mismatches == 0 && tests_run > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask
  task automatic cyc(input int n);
    repeat (n) @(posedge clk_i);
  endtask
  // Wait window in cycles for a delay field
  function automatic int win(input logic [2:0] f);
    return UNIT << f;
  endfunction
  // Arms the action, then heats one step above the limit
  task automatic heat(input logic [7:0] act);
    h.wr(overtemp_fault_pkg::CMD_OT_FAULT_ACTION, {8'h00, act});
    @(posedge clk_i);
    temp_reading_i <= lim + 16'h0001;
  endtask
  // Cools to the limit, clears all and expects the output back
  task automatic recover();
    temp_reading_i <= lim;
    h.clr(1'b1);
    cyc(8);
    `CHK({output_en_o, ot_fault_status_o}, 2'b10)
  endtask
  initial begin
    void'($urandom(13));
    cyc(6);
    reset_n_i <= 1'b1;
    foreach (codes[i]) begin
      h.rd(codes[i], v);
      `CHK(v, i == 3 ? 16'h0000 : overtemp_fault_pkg::LIMIT_RESET)
      v = 16'($urandom);
      h.wr(codes[i], v);
      h.rd(codes[i], lim);
      `CHK(lim, i == 3 ? {8'h00, v[7:0]} : v)
    end
    h.rd(8'h52, v);
    `CHK(v, 16'h0000)
    lim = 16'($urandom_range(16'h3f0, 16'h040));
    h.wr(8'h4f, lim);
    h.wr(8'h51, lim);
    h.wr(8'h4a, 16'h0100);
    h.wr(8'h48, 16'h0001);
    $display("registers done");
    h.wr(overtemp_fault_pkg::CMD_OT_FAULT_ACTION, {8'h00, 2'h0, 6'($urandom)});
    temp_reading_i <= lim;
    {operation_on_i, ctrl_pin_i} <= 2'b11;
    cyc(8);
    `CHK({output_en_o, ot_fault_status_o, oc_warn_status_o}, 3'b101)
    temp_reading_i <= lim + 16'h0001;
    cyc(4);
    `CHK({output_en_o, ot_fault_status_o, ot_warn_status_o}, 3'b111)
    recover();
    $display("ignore done");
    foreach (rs[i]) begin
      d = 3'($urandom_range(2));
      w = win(d);
      heat({2'h2, rs[i], d});
      cyc(3);
      `CHK(output_en_o, 1'b0)
      if (rs[i] != 3'h0) begin
        cyc(rs[i] * w - 4);
        `CHK(retrying_o, 1'b1)
        cyc(4);
        `CHK({output_en_o, retrying_o}, 2'b00)
      end
      cyc((rs[i] + 2) * w + 6);
      `CHK({output_en_o, retrying_o}, 2'b00)
      recover();
    end
    $display("bounded retry done");
    heat(8'hb9);
    cyc(3 * win(3'h1));
    `CHK(retrying_o, 1'b1)
    temp_reading_i <= lim;
    cyc(2 * win(3'h1) + 4);
    `CHK(output_en_o, 1'b1)
    temp_reading_i <= lim + 16'h0001;
    cyc(6);
    other_fault_off_i <= 1'b1;
    cyc(4);
    `CHK({output_en_o, retrying_o}, 2'b00)
    other_fault_off_i <= 1'b0;
    recover();
    $display("endless retry done");
    heat(8'h42);
    cyc(win(3'h2));
    `CHK(output_en_o, 1'b1)
    cyc(6);
    `CHK(output_en_o, 1'b0)
    recover();
    heat(8'hc0);
    cyc(6);
    temp_reading_i <= lim;
    cyc(8);
    `CHK({output_en_o, ot_fault_status_o}, 2'b01)
    operation_on_i <= 1'b0;
    cyc(3);
    operation_on_i <= 1'b1;
    cyc(8);
    `CHK(output_en_o, 1'b1)
    $display("delayed and latched done");
    print_verdict();
  end
endmodule
